//--- adc_conversion_sequencer.sv
// Conversion sequencer top: acquisition, successive approximation, result and flag.
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_consts.svh"
module adc_conversion_sequencer
    import adc_seq_pkg::*;
#(
    parameter int NPINS = 13
) (
    input wire logic MCLK,
    input wire logic NRST,
    input wire logic POR_N,
    input wire converter_config_t CONFIG,
    input wire logic START,
    input wire logic FLAG_CLEAR,
    input wire logic CONVERSION_IRQ_ENABLE,
    input wire logic GLOBAL_IRQ_ENABLE,
    input wire logic SLEEP,
    input wire logic COMPARATOR_IN,
    input wire logic [NPINS-1:0] ANALOG_SELECT,
    input wire logic [NPINS-1:0] PORT_PIN_IN,
    output logic BUSY,
    output logic CONVERSION_COMPLETE_FLAG,
    output logic IRQ,
    output logic [7:0] RESULT_HIGH_BYTE,
    output logic [7:0] RESULT_LOW_BYTE,
    output logic [`RES_BITS-1:0] DAC_CODE,
    output logic SAMPLE_CONNECT,
    output logic [3:0] CHANNEL_SELECT,
    output logic REF_PINS_SELECT,
    output logic [NPINS-1:0] DIGITAL_INPUT_ENABLE,
    output logic [NPINS-1:0] PORT_READ
);
    localparam logic [39:0] ACQS = `ACQ_TABLE;
    localparam logic [3:0] DLY_CLKS = 4'(`INSTR_CYCLE_CLKS);

    if (NPINS < 1 || NPINS > 16) begin : g_chk
        $error("adc_conversion_sequencer: NPINS must be 1 to 16");
    end

    seq_state_t state_q, state_d;       // Sequencer state
    logic busy_d;                       // Start/busy bit
    logic flag_d, irq_d;                // Completion flag and request
    logic [4:0] tads_q, tads_d;         // Bit periods left in phase
    logic [3:0] dly_q, dly_d;           // Instruction-cycle delay counter
    logic [3:0] bit_q, bit_d;           // Bit under trial
    logic [`RES_BITS-1:0] sar_d;        // Trial code next
    logic load_res;                     // Result load strobe
    logic [`RES_BITS-1:0] final_res;    // Resolved code
    logic tick;                         // One bit period elapsed
    logic rc_sel;                       // Internal RC clock chosen
    logic tick_run;                     // Divider allowed to run

    assign rc_sel = (CONFIG.clk_select == `CLK_SEL_RC_A) ||
                    (CONFIG.clk_select == `CLK_SEL_RC_B);
    assign tick_run = CONFIG.enable && !state_q[0] && (!SLEEP || rc_sel);

    tad_divider #(.CNT_W(16)) u_tad (
        .MCLK(MCLK),
        .NRST(NRST),
        .run(tick_run),
        .sel(CONFIG.clk_select),
        .tick(tick)
    );

    // Sequencer next state
    always_comb begin
        state_d = state_q;
        busy_d = BUSY;
        tads_d = tads_q;
        dly_d = dly_q;
        bit_d = bit_q;
        sar_d = DAC_CODE;
        load_res = 1'b0;
        final_res = DAC_CODE;
        if (!CONFIG.enable) begin
            state_d = ST_IDLE;
            busy_d = 1'b0;
            sar_d = '0;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (START) begin
                        busy_d = 1'b1;
                        tads_d = ACQS[{CONFIG.acq_select, 2'h0} + {3'h0, CONFIG.acq_select} +: 5];
                        if (CONFIG.acq_select == 3'h0) begin
                            state_d = ST_DELAY;
                            dly_d = DLY_CLKS - 4'h1;
                        end else begin
                            state_d = ST_ACQ;
                        end
                    end
                end
                ST_DELAY: begin
                    if (dly_q == 4'h0) begin
                        state_d = ST_CONV;
                        bit_d = 4'(`RES_BITS - 1);
                        sar_d = {1'b1, {(`RES_BITS-1){1'b0}}};
                    end else begin
                        dly_d = dly_q - 4'h1;
                    end
                end
                ST_ACQ: begin
                    if (tick) begin
                        if (tads_q <= 5'h1) begin
                            state_d = ST_CONV;
                            bit_d = 4'(`RES_BITS - 1);
                            sar_d = {1'b1, {(`RES_BITS-1){1'b0}}};
                        end else begin
                            tads_d = tads_q - 5'h1;
                        end
                    end
                end
                ST_CONV: begin
                    if (tick) begin
                        final_res = DAC_CODE;
                        final_res[bit_q] = COMPARATOR_IN;
                        sar_d = final_res;
                        if (bit_q == 4'h0) begin
                            load_res = 1'b1;
                            busy_d = 1'b0;
                            state_d = ST_HOLD;
                            tads_d = {1'b0, `HOLDOFF_TADS};
                        end else begin
                            bit_d = bit_q - 4'h1;
                            sar_d[bit_q - 4'h1] = 1'b1;
                        end
                    end
                end
                ST_HOLD: begin
                    if (tick) begin
                        if (tads_q <= 5'h1) begin
                            state_d = ST_IDLE;
                        end else begin
                            tads_d = tads_q - 5'h1;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            state_q <= ST_IDLE;
            BUSY <= 1'b0;
            tads_q <= 5'h0;
            dly_q <= 4'h0;
            bit_q <= 4'h0;
            DAC_CODE <= '0;
        end else begin
            state_q <= state_d;
            BUSY <= busy_d;
            tads_q <= tads_d;
            dly_q <= dly_d;
            bit_q <= bit_d;
            DAC_CODE <= sar_d;
        end
    end

    // Flag and interrupt next values
    always_comb begin
        flag_d = load_res | (CONVERSION_COMPLETE_FLAG & ~FLAG_CLEAR);
        irq_d = flag_d & CONVERSION_IRQ_ENABLE & GLOBAL_IRQ_ENABLE;
    end

    // Register flag and interrupt
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            CONVERSION_COMPLETE_FLAG <= 1'b0;
            IRQ <= 1'b0;
        end else begin
            CONVERSION_COMPLETE_FLAG <= flag_d;
            IRQ <= irq_d;
        end
    end

    logic [15:0] res_d; // Result pair next value
    always_comb begin
        res_d = {RESULT_HIGH_BYTE, RESULT_LOW_BYTE};
        if (load_res) begin
            res_d = CONFIG.right_just ? {4'h0, final_res} : {final_res, 4'h0};
        end
    end

    always_ff @(posedge MCLK or negedge POR_N) begin
        if (!POR_N) begin
            {RESULT_HIGH_BYTE, RESULT_LOW_BYTE} <= `RESULT_RESET;
        end else begin
            {RESULT_HIGH_BYTE, RESULT_LOW_BYTE} <= res_d;
        end
    end

    logic sample_d; // Holding capacitor switch
    always_comb begin
        sample_d = CONFIG.enable && !state_d[3];
    end

    // Analog-side selections and switch
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            SAMPLE_CONNECT <= 1'b0;
            CHANNEL_SELECT <= 4'h0;
            REF_PINS_SELECT <= 1'b0;
        end else begin
            SAMPLE_CONNECT <= sample_d;
            CHANNEL_SELECT <= CONFIG.channel;
            REF_PINS_SELECT <= CONFIG.ref_pins;
        end
    end

    // Per-pin analog or digital function
    for (genvar p = 0; p < NPINS; p++) begin : g_pin
        logic din_d;  // Digital buffer on
        logic read_d; // Port read value
        always_comb begin
            din_d = !ANALOG_SELECT[p];
            read_d = ANALOG_SELECT[p] ? 1'b0 : PORT_PIN_IN[p];
        end
        always_ff @(posedge MCLK or negedge NRST) begin
            if (!NRST) begin
                DIGITAL_INPUT_ENABLE[p] <= 1'b0;
                PORT_READ[p] <= 1'b0;
            end else begin
                DIGITAL_INPUT_ENABLE[p] <= din_d;
                PORT_READ[p] <= read_d;
            end
        end
    end
endmodule // adc_conversion_sequencer
`default_nettype wire

//--- adc_seq_consts.svh
// Constants for the conversion sequencer: codes, counts and reset values.
// Operation
// - Twelve-bit result, programmable acquisition period.
// - Reference is supply rails or pins.
// - Converts in sleep only on RC clock.
// - Successive approximation resolves one bit each.
// - Reset clears registers, turns off, aborts.
// - Completion loads result, clears busy, flags.
// - Result cleared to zero at power-on, kept otherwise.
// - Programmed acquisition runs after start bit.
// - Each shared pin analog or digital.
// - One bit period is the timing unit.
// - Two bit periods before next acquisition.
// - Zero acquisition delays one instruction cycle.
// - Holding capacitor disconnects at conversion start.
// - Analog pins read zero on port.
`ifndef ADC_SEQ_CONSTS_SVH
`define ADC_SEQ_CONSTS_SVH

`define RES_BITS 12
`define CLK_PERIOD_NS 10
`define INSTR_CYCLE_NS 40
`define INSTR_CYCLE_CLKS ((`INSTR_CYCLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HOLDOFF_TADS 4'h2
`define CLK_SEL_RC_A 3'h3
`define CLK_SEL_RC_B 3'h7
`define RC_DIVISOR 16'h0040
`define DIV_TABLE {16'h0040, 16'h0040, 16'h0020, 16'h0008, 16'h0040, 16'h0040, 16'h0010, 16'h0004}
`define ACQ_TABLE {5'h14, 5'h10, 5'h0c, 5'h08, 5'h06, 5'h04, 5'h02, 5'h00}
`define RESULT_RESET 16'h0000

`endif

//--- adc_seq_pkg.sv
// Types shared by the conversion sequencer modules.
package adc_seq_pkg;

    // Software configuration of the converter
    typedef struct packed {
        logic       enable;       // Module on
        logic [3:0] channel;      // Selected analog channel
        logic       ref_pins;     // 1: reference pins, 0: supply rails
        logic [2:0] acq_select;   // Automatic acquisition time code
        logic [2:0] clk_select;   // Conversion clock code
        logic       right_just;   // Result justification
    } converter_config_t;

    // Sequencer states, one-hot
    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_DELAY = 5'b00010,
        ST_ACQ   = 5'b00100,
        ST_CONV  = 5'b01000,
        ST_HOLD  = 5'b10000
    } seq_state_t;

endpackage

//--- tad_divider.sv
// Bit-period tick generator: divides MCLK by the selected conversion clock.
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_consts.svh"
module tad_divider #(
    parameter int CNT_W = 16
) (
    input wire logic MCLK,
    input wire logic NRST,
    input wire logic run,
    input wire logic [2:0] sel,
    output logic tick
);
    // Divisor per clock code, packed high code first
    localparam logic [127:0] DIVS = `DIV_TABLE;

    if (CNT_W < 16) begin : g_chk
        $error("tad_divider: CNT_W too small for divisor table");
    end

    logic [CNT_W-1:0] cnt_q, cnt_d; // Cycles left in this period
    logic tick_d;
    logic [15:0] div_now;

    // Next count and tick
    always_comb begin
        div_now = DIVS[{sel, 4'h0} +: 16];
        cnt_d = cnt_q;
        tick_d = 1'b0;
        if (!run) begin
            // Stopped: restart a full period when released
            cnt_d = CNT_W'(div_now - 16'h0001);
        end else if (cnt_q == '0) begin
            cnt_d = CNT_W'(div_now - 16'h0001);
            tick_d = 1'b1;
        end else begin
            cnt_d = cnt_q - CNT_W'(1);
        end
    end

    // Register count and tick
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            cnt_q <= '0;
            tick <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick <= tick_d;
        end
    end
endmodule // tad_divider
`default_nettype wire

//--- adc_analog_model.sv
// Analog front end model: sample-and-hold and comparator.
`timescale 1ns/1ps
`default_nettype none
module adc_analog_model (
    input wire logic MCLK,
    input wire logic [11:0] level,
    input wire logic SAMPLE_CONNECT,
    input wire logic [11:0] DAC_CODE,
    output logic COMPARATOR_IN
);
    logic [11:0] held_q = 12'h000; // Held sample
    always @(posedge MCLK) if (SAMPLE_CONNECT) held_q <= level;
    // compare held sample with trial code
    assign COMPARATOR_IN = (held_q >= DAC_CODE);
endmodule // adc_analog_model
`default_nettype wire

//--- adc_seq_chk.sv
// Port checker for the conversion sequencer.
`timescale 1ns/1ps
`default_nettype none
module adc_seq_chk
    import adc_seq_pkg::*;
#(
    parameter int NPINS = 13
) (
    input wire logic MCLK,
    input wire logic NRST,
    input wire logic POR_N,
    input wire converter_config_t CONFIG,
    input wire logic START,
    input wire logic FLAG_CLEAR,
    input wire logic CONVERSION_IRQ_ENABLE,
    input wire logic GLOBAL_IRQ_ENABLE,
    input wire logic [NPINS-1:0] ANALOG_SELECT,
    input wire logic [NPINS-1:0] PORT_PIN_IN,
    input wire logic BUSY,
    input wire logic CONVERSION_COMPLETE_FLAG,
    input wire logic IRQ,
    input wire logic [7:0] RESULT_HIGH_BYTE,
    input wire logic [7:0] RESULT_LOW_BYTE,
    input wire logic SAMPLE_CONNECT,
    input wire logic [NPINS-1:0] DIGITAL_INPUT_ENABLE,
    input wire logic [NPINS-1:0] PORT_READ
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!NRST || !POR_N);
    AST_BUSY_FROM_START: assert property ($rose(BUSY) |-> $past(START))
        else $error("Busy rose without a start");
    AST_DONE_FLAG: assert property ($fell(BUSY) && $past(CONFIG.enable)
        |-> CONVERSION_COMPLETE_FLAG && $past(BUSY, 8)) else $error("Completion flag missing");
    AST_FLAG_STICKY: assert property ($fell(CONVERSION_COMPLETE_FLAG) |-> $past(FLAG_CLEAR))
        else $error("Flag dropped without clear");
    AST_IRQ_GATE: assert property (IRQ == (CONVERSION_COMPLETE_FLAG
        && $past(CONVERSION_IRQ_ENABLE && GLOBAL_IRQ_ENABLE)))
        else $error("Interrupt gating wrong");
    AST_PORT_READ: assert property ($past(NRST)
        |-> PORT_READ == $past(PORT_PIN_IN & ~ANALOG_SELECT))
        else $error("Port read of analog pin");
    AST_DIGITAL_EN: assert property ($past(NRST)
        |-> DIGITAL_INPUT_ENABLE == ~$past(ANALOG_SELECT))
        else $error("Digital input enable wrong");
    AST_SAMPLE_OFF: assert property ($fell(SAMPLE_CONNECT) && $past(CONFIG.enable)
        |-> BUSY) else $error("Sample switch opened while idle");
    AST_ABORT: assert property (!CONFIG.enable |=> !BUSY && !$rose(CONVERSION_COMPLETE_FLAG))
        else $error("Disable did not abort");
    AST_RESULT_HOLD: assert property (!$fell(BUSY) |-> $stable(RESULT_HIGH_BYTE)
        && $stable(RESULT_LOW_BYTE)) else $error("Result changed outside completion");
    AST_HOLDOFF: assert property ($fell(BUSY) && $past(CONFIG.enable) |-> !BUSY [*8])
        else $error("Restart inside holdoff");
    AST_RIGHT_JUST: assert property ($fell(BUSY) && $past(CONFIG.enable)
        && $past(CONFIG.right_just) |-> RESULT_HIGH_BYTE[7:4] == 4'h0)
        else $error("High byte not justified");
endmodule // adc_seq_chk
bind adc_conversion_sequencer adc_seq_chk #(.NPINS(NPINS)) u_adc_seq_chk (
    .MCLK(MCLK), .NRST(NRST), .POR_N(POR_N), .CONFIG(CONFIG), .START(START),
    .FLAG_CLEAR(FLAG_CLEAR), .CONVERSION_IRQ_ENABLE(CONVERSION_IRQ_ENABLE),
    .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE), .ANALOG_SELECT(ANALOG_SELECT),
    .PORT_PIN_IN(PORT_PIN_IN), .BUSY(BUSY), .CONVERSION_COMPLETE_FLAG(CONVERSION_COMPLETE_FLAG),
    .IRQ(IRQ), .RESULT_HIGH_BYTE(RESULT_HIGH_BYTE), .RESULT_LOW_BYTE(RESULT_LOW_BYTE),
    .SAMPLE_CONNECT(SAMPLE_CONNECT), .DIGITAL_INPUT_ENABLE(DIGITAL_INPUT_ENABLE),
    .PORT_READ(PORT_READ));
`default_nettype wire

//--- testbench.sv
// Self-checking bench for the conversion sequencer.
`timescale 1ns/1ps
`default_nettype none
module testbench
    import adc_seq_pkg::*;
;
    logic mclk = 1'b0, nrst = 1'b0, por_n = 1'b0, start = 1'b0, clr = 1'b0;
    logic cie = 1'b0, global_irq_enable = 1'b0, sleep = 1'b0, comp, busy, flag, irq, sc, rp;
    logic [12:0] analog = 13'h0000, pins = 13'h0000, die, pr;
    logic [11:0] level = 12'h000, dac;
    logic [7:0] rh, rl;
    logic [3:0] ch;
    logic [15:0] last;
    converter_config_t cfg = '0;
    logic [11:0] vals [8] = '{12'h000, 12'hfff, 12'ha5c, 12'h123, 12'h800, 12'h7ff, 12'h001, 12'h3c6};
    int mismatches = 0, comparisons = 0, cycles = 0;
    // Clock, 10 ns period
    always #5 mclk = ~mclk;
    adc_conversion_sequencer #(.NPINS(13)) u_adc_conversion_sequencer (
        .MCLK(mclk), .NRST(nrst), .POR_N(por_n), .CONFIG(cfg), .START(start),
        .FLAG_CLEAR(clr), .CONVERSION_IRQ_ENABLE(cie), .GLOBAL_IRQ_ENABLE(global_irq_enable), .SLEEP(sleep),
        .COMPARATOR_IN(comp), .ANALOG_SELECT(analog), .PORT_PIN_IN(pins), .BUSY(busy),
        .CONVERSION_COMPLETE_FLAG(flag), .IRQ(irq), .RESULT_HIGH_BYTE(rh), .RESULT_LOW_BYTE(rl),
        .DAC_CODE(dac), .SAMPLE_CONNECT(sc), .CHANNEL_SELECT(ch), .REF_PINS_SELECT(rp),
        .DIGITAL_INPUT_ENABLE(die), .PORT_READ(pr));
    adc_analog_model u_adc_analog_model (
        .MCLK(mclk), .level(level), .SAMPLE_CONNECT(sc), .DAC_CODE(dac), .COMPARATOR_IN(comp));
    // Compare and count
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Clear flag, configure, wait out holdoff, pulse start
    task automatic prep(input logic [11:0] v, input logic [2:0] ck, input logic [2:0] aq,
                        input logic rj);
        level = v;
        cfg.clk_select = ck;
        cfg.acq_select = aq;
        cfg.right_just = rj;
        clr = 1'b1;
        @(negedge mclk);
        clr = 1'b0;
        repeat (130) @(negedge mclk);
        start = 1'b1;
        @(negedge mclk);
        start = 1'b0;
        chk(busy, 1);
    endtask
    // Wait for completion, check flag and result pair
    task automatic fin(input logic [11:0] v, input logic rj);
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 5000) begin
            @(negedge mclk);
            n++;
        end
        last = rj ? {4'h0, v} : {v, 4'h0};
        chk(flag, 1);
        chk({rh, rl}, last);
    endtask
    // Verdict
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Hang guard
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 60000) begin
            mismatches++;
            finish_test();
        end
    end
    initial begin
        repeat (12) @(negedge mclk);
        nrst = 1'b1;
        por_n = 1'b1;
        analog = 13'h0f0f;
        pins = 13'h1fff;
        cfg.channel = 4'h5;
        cfg.ref_pins = 1'b1;
        cfg.enable = 1'b1;
        @(negedge mclk);
        chk(pr, 16'h10f0);
        chk(die, 16'h10f0);
        chk({ch, rp}, 16'h000b);
        chk({rh, rl}, 16'h0000);
        // Every clock and acquisition code
        for (int i = 0; i < 8; i++) begin
            prep(vals[i], 3'(i), 3'(7 - i), i[0]);
            fin(vals[i], i[0]);
        end
        start = 1'b1;
        @(negedge mclk);
        start = 1'b0;
        @(negedge mclk);
        chk(busy, 0);
        cie = 1'b1;
        repeat (2) @(negedge mclk);
        chk(irq, 0);
        global_irq_enable = 1'b1;
        @(negedge mclk);
        chk(irq, 1);
        clr = 1'b1;
        @(negedge mclk);
        clr = 1'b0;
        chk(flag, 0);
        chk(irq, 0);
        // Sleep converts on RC clock, stalls otherwise
        sleep = 1'b1;
        prep(12'h5a5, 3'h3, 3'h0, 1'b1);
        fin(12'h5a5, 1'b1);
        repeat (130) @(negedge mclk);
        prep(12'h2b7, 3'h0, 3'h1, 1'b0);
        repeat (200) @(negedge mclk);
        chk(busy, 1);
        sleep = 1'b0;
        fin(12'h2b7, 1'b0);
        // Abort by disable, then by device reset
        prep(12'h0aa, 3'h0, 3'h7, 1'b1);
        repeat (20) @(negedge mclk);
        cfg.enable = 1'b0;
        repeat (2) @(negedge mclk);
        chk({busy, flag}, 0);
        chk({rh, rl}, last);
        cfg.enable = 1'b1;
        cfg.channel = 4'ha;
        cfg.ref_pins = 1'b0;
        prep(12'h0aa, 3'h0, 3'h7, 1'b1);
        repeat (20) @(negedge mclk);
        chk({ch, rp}, 16'h0014);
        nrst = 1'b0;
        @(negedge mclk);
        chk({busy, flag, ch}, 0);
        nrst = 1'b1;
        chk({rh, rl}, last);
        @(negedge mclk);
        chk({pr, busy}, 16'h21e0);
        finish_test();
    end
endmodule // testbench
`default_nettype wire
